// ### smpeg_force_lim.sv
/*
 * Force limiter: clamps the force request between the forward cap and
 * the negated reverse cap, both in percent of rated force. Assumes the
 * request is a signed percent value.
 */
`timescale 1ns/1ps
module smpeg_force_lim
    import smpeg_pkg::*;
(
    // Clock and reset
    input logic clk,
    input logic rst,
    // Request and caps
    input logic signed [15:0] req,
    input logic [15:0] fwd_cap,
    input logic [15:0] rev_cap,
    // Limited force
    output logic signed [15:0] force_out
);
    logic signed [16:0] hi;
    logic signed [16:0] lo;
    logic signed [15:0] next_force;

    ////////////////////////////////////////////////////////////////////////
    // Clamp; widened to 17 bits so a full-scale cap cannot wrap
    assign hi = $signed({1'b0, fwd_cap});
    assign lo = -$signed({1'b0, rev_cap});

    always_comb begin
        if (17'(req) > hi) begin
            next_force = 16'(hi);
        end else if (17'(req) < lo) begin
            next_force = 16'(lo);
        end else begin
            next_force = req;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            force_out <= 16'sh0000;
        end else begin
            force_out <= next_force;
        end
    end

    force_window_a: assert property (@(posedge clk) disable iff (rst)
        ##1 (17'(force_out) <= $past(hi) && 17'(force_out) >= $past(lo)))
        else $error("force left its limits");
endmodule : smpeg_force_lim

// ### smpeg_guard.sv
/*
 * Servo monitor and position error guard: two analog monitor channels
 * and the excessive position error protection, including the checks at
 * servo switch-on. Assumes all inputs are synchronous to REF_CLK and
 * that configuration is loaded by a one-cycle CFG_LOAD pulse.
 */
`timescale 1ns/1ps
module smpeg_guard
    import smpeg_pkg::*;
(
    // Clock and reset
    input logic REF_CLK,
    input logic RST,
    // Configuration, captured on CFG_LOAD
    input logic CFG_LOAD,
    input logic [3:0] MON1_SEL,
    input logic [3:0] MON2_SEL,
    input logic [29:0] EXCESS_LEVEL,
    input logic [29:0] SWON_LEVEL,
    input logic [13:0] SPEED_CAP,
    input logic [3:0] CLEAR_SETTING,
    input logic [15:0] FWD_FORCE_CAP,
    input logic [15:0] REV_FORCE_CAP,
    input logic [15:0] LOOP_GAIN,
    input logic [15:0] PULSES_PER_UNIT,
    // Control from host
    input logic [2:0] MODE,
    input logic SERVO_ON,
    input logic NEW_REF,
    input logic ALARM_CLEAR,
    // Loop quantities
    input logic [31:0] POS_REF,
    input logic [31:0] POS_ACT,
    input logic [31:0] SPEED_FB,
    input logic [31:0] SPEED_REF,
    input logic [31:0] FORCE_REF,
    input logic [31:0] AMP_ERR,
    input logic [31:0] REF_SPEED,
    input logic [31:0] SPEED_FF,
    input logic [31:0] FORCE_FF,
    input logic POS_DONE,
    input logic GAIN2_ACTIVE,
    input logic REF_DONE,
    input logic signed [15:0] FORCE_REQ,
    // Monitor outputs
    output logic [31:0] MON1,
    output logic [31:0] MON2,
    // Guard outputs
    output logic [31:0] POS_ERR,
    output logic ERR_CLEAR,
    output logic MOTOR_STOP,
    output logic SPEED_LIMIT_ON,
    output logic [13:0] SPEED_LIMIT,
    output logic LAG_OVER_STEADY,
    output logic EXCESS_ALARM,
    output logic SWITCH_ON_OVERFLOW_ALARM,
    output logic SPEED_CAP_OVERFLOW_ALARM,
    output logic signed [15:0] FORCE_OUT
);
    logic [3:0] mon_sel [2];
    logic [3:0] next_mon_sel [2];
    logic [29:0] excess_lvl, next_excess_lvl;
    logic [29:0] swon_lvl, next_swon_lvl;
    logic [13:0] cap, next_cap;
    logic [3:0] clr_set, next_clr_set;
    logic [15:0] fwd_cap, next_fwd_cap;
    logic [15:0] rev_cap, next_rev_cap;
    logic [15:0] gain, next_gain;
    logic [15:0] ppu, next_ppu;
    logic [31:0] err, next_err;
    logic [31:0] err_mag;
    logic [31:0] spd_mag;
    logic err_keep;
    logic servo_q;
    logic sw_on;
    logic pos_mode;
    logic next_err_clr;
    logic next_lag;
    logic [51:0] lag_x;
    logic [51:0] steady_x;
    logic excess_hit, swon_hit, cap_hit;
    logic next_exc, next_swon, next_capov;
    smpeg_state_t state, next_state;

    smpeg_qty_if qty ();

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers; levels below one are raised to one and the
    // speed cap is held to its maximum so software cannot disarm the guard
    always_comb begin
        next_mon_sel = mon_sel;
        next_excess_lvl = excess_lvl;
        next_swon_lvl = swon_lvl;
        next_cap = cap;
        next_clr_set = clr_set;
        next_fwd_cap = fwd_cap;
        next_rev_cap = rev_cap;
        next_gain = gain;
        next_ppu = ppu;
        if (CFG_LOAD) begin
            next_mon_sel[0] = MON1_SEL;
            next_mon_sel[1] = MON2_SEL;
            next_excess_lvl = (EXCESS_LEVEL < LVL_MIN) ? LVL_MIN : EXCESS_LEVEL;
            next_swon_lvl = (SWON_LEVEL < LVL_MIN) ? LVL_MIN : SWON_LEVEL;
            next_cap = (SPEED_CAP > CAP_MAX) ? CAP_MAX : SPEED_CAP;
            next_clr_set = CLEAR_SETTING;
            next_fwd_cap = FWD_FORCE_CAP;
            next_rev_cap = REV_FORCE_CAP;
            next_gain = LOOP_GAIN;
            next_ppu = PULSES_PER_UNIT;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            mon_sel[0] <= MON1_RST;
            mon_sel[1] <= MON2_RST;
            excess_lvl <= EXCESS_RST;
            swon_lvl <= SWON_RST;
            cap <= CAP_RST;
            clr_set <= 4'h0;
            fwd_cap <= FCAP_RST;
            rev_cap <= FCAP_RST;
            gain <= GAIN_RST;
            ppu <= PPU_RST;
        end else begin
            mon_sel <= next_mon_sel;
            excess_lvl <= next_excess_lvl;
            swon_lvl <= next_swon_lvl;
            cap <= next_cap;
            clr_set <= next_clr_set;
            fwd_cap <= next_fwd_cap;
            rev_cap <= next_rev_cap;
            gain <= next_gain;
            ppu <= next_ppu;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Position error; while off with a zero clear setting it is held at
    // zero and the loop is told to follow the actual position
    assign err_keep = (clr_set != 4'h0);
    assign pos_mode = (MODE == MODE_POS);
    assign err_mag = err[31] ? 32'(-err) : err;
    assign spd_mag = SPEED_FB[31] ? 32'(-SPEED_FB) : SPEED_FB;
    assign sw_on = SERVO_ON & ~servo_q;

    // Steady lag test without a divider: err*gain > speed*ppu*10
    assign lag_x = 52'(err_mag) * 52'(gain);
    assign steady_x = 52'(spd_mag) * 52'(ppu) * GAIN_SCALE;

    always_comb begin
        if (!SERVO_ON && !err_keep) begin
            next_err = 32'h0000_0000;
        end else begin
            next_err = 32'(POS_REF - POS_ACT);
        end
        next_err_clr = !SERVO_ON && !err_keep;
        next_lag = pos_mode && (lag_x > steady_x);
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            err <= 32'h0000_0000;
            servo_q <= 1'b0;
            ERR_CLEAR <= 1'b0;
            LAG_OVER_STEADY <= 1'b0;
        end else begin
            err <= next_err;
            servo_q <= SERVO_ON;
            ERR_CLEAR <= next_err_clr;
            LAG_OVER_STEADY <= next_lag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trip conditions
    assign excess_hit = (state == ST_RUN) && pos_mode
        && (err_mag >= 32'(excess_lvl));
    assign swon_hit = (state == ST_OFF) && sw_on
        && (err_mag > 32'(swon_lvl));
    assign cap_hit = (state == ST_CAP) && SERVO_ON && NEW_REF
        && (err_mag > 32'(excess_lvl));

    ////////////////////////////////////////////////////////////////////////
    // Guard state machine and latched alarms; a new trip wins over clear
    always_comb begin
        next_exc = (EXCESS_ALARM & ~ALARM_CLEAR) | excess_hit;
        next_swon = (SWITCH_ON_OVERFLOW_ALARM & ~ALARM_CLEAR) | swon_hit;
        next_capov = (SPEED_CAP_OVERFLOW_ALARM & ~ALARM_CLEAR) | cap_hit;
        next_state = state;
        case (state)
            ST_OFF: begin
                if (swon_hit) begin
                    next_state = ST_STOP;
                end else if (sw_on && err_keep && err_mag != 32'h0) begin
                    next_state = ST_CAP;
                end else if (sw_on) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (excess_hit) begin
                    next_state = ST_STOP;
                end else if (!SERVO_ON) begin
                    next_state = ST_OFF;
                end
            end
            ST_CAP: begin
                if (cap_hit) begin
                    next_state = ST_STOP;
                end else if (!SERVO_ON) begin
                    next_state = ST_OFF;
                end else if (err_mag == 32'h0) begin
                    next_state = ST_RUN;
                end
            end
            ST_STOP: begin
                if (ALARM_CLEAR) begin
                    next_state = ST_OFF;
                end
            end
            default: next_state = ST_OFF;
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state <= ST_OFF;
            EXCESS_ALARM <= 1'b0;
            SWITCH_ON_OVERFLOW_ALARM <= 1'b0;
            SPEED_CAP_OVERFLOW_ALARM <= 1'b0;
        end else begin
            state <= next_state;
            EXCESS_ALARM <= next_exc;
            SWITCH_ON_OVERFLOW_ALARM <= next_swon;
            SPEED_CAP_OVERFLOW_ALARM <= next_capov;
        end
    end

    // State-derived outputs, plus the speed cap value and the position error
    assign MOTOR_STOP = (state == ST_STOP);
    assign SPEED_LIMIT_ON = (state == ST_CAP);
    assign SPEED_LIMIT = cap;
    assign POS_ERR = err;

    ////////////////////////////////////////////////////////////////////////
    // Monitor quantities and the two channels
    assign qty.speed = SPEED_FB;
    assign qty.spd_ref = SPEED_REF;
    assign qty.frc_ref = FORCE_REF;
    assign qty.pos_err = pos_mode ? err : 32'h0000_0000;
    assign qty.amp_err = pos_mode ? AMP_ERR : 32'h0000_0000;
    assign qty.ref_spd = REF_SPEED;
    assign qty.spd_ff = SPEED_FF;
    assign qty.frc_ff = FORCE_FF;
    assign qty.pos_done = POS_DONE;
    assign qty.gain2 = GAIN2_ACTIVE;
    assign qty.ref_done = REF_DONE;

    logic [31:0] mon_word [2];

    for (genvar ch = 0; ch < 2; ch++) begin : g_mon
        smpeg_mon_sel u_mon (
            .clk(REF_CLK),
            .rst(RST),
            .sel(mon_sel[ch]),
            .qty(qty),
            .mon(mon_word[ch])
        );
    end

    assign MON1 = mon_word[0];
    assign MON2 = mon_word[1];

    smpeg_force_lim u_force (
        .clk(REF_CLK),
        .rst(RST),
        .req(FORCE_REQ),
        .fwd_cap(fwd_cap),
        .rev_cap(rev_cap),
        .force_out(FORCE_OUT)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence swon_over_s;
        state == ST_OFF && sw_on && err_mag > 32'(swon_lvl);
    endsequence

    sequence cap_entry_s;
        state == ST_OFF && sw_on && !swon_hit && err_keep
            && err_mag != 32'h0;
    endsequence

    err_diff_a: assert property ($past(SERVO_ON) |->
        err == 32'($past(POS_REF) - $past(POS_ACT)))
        else $error("position error is not reference minus actual");
    err_zero_mon_a: assert property ((mon_sel[0] == SEL_POS_ERR
        && !pos_mode) |=> MON1 == 32'h0)
        else $error("position error monitor not zero off position mode");
    done_level_a: assert property ((mon_sel[1] == SEL_POS_DONE
        && POS_DONE) |=> MON2 == LVL_HIGH)
        else $error("positioning done not shown as high level");
    excess_trip_a: assert property ((state == ST_RUN && pos_mode
        && err_mag >= 32'(excess_lvl)) |=> EXCESS_ALARM && MOTOR_STOP)
        else $error("excess error did not stop the motor");
    mode_only_a: assert property ((state == ST_RUN && !pos_mode
        && !EXCESS_ALARM) |=> !EXCESS_ALARM)
        else $error("excess alarm outside position control");
    swon_alarm_a: assert property (swon_over_s |=>
        SWITCH_ON_OVERFLOW_ALARM ##0 MOTOR_STOP)
        else $error("switch-on overflow not raised");
    cap_entry_a: assert property (cap_entry_s |=>
        SPEED_LIMIT_ON && SPEED_LIMIT == $past(cap))
        else $error("speed cap not applied at switch-on");
    cap_trip_a: assert property (cap_hit |=>
        SPEED_CAP_OVERFLOW_ALARM && MOTOR_STOP)
        else $error("speed cap overflow not raised");
    cap_release_a: assert property ((state == ST_CAP && SERVO_ON
        && err_mag == 32'h0) |=> !SPEED_LIMIT_ON ##1 1'b1)
        else $error("speed cap held after error reached zero");
    keep_err_a: assert property ((!SERVO_ON && err_keep) |=>
        !ERR_CLEAR && err == 32'($past(POS_REF) - $past(POS_ACT)))
        else $error("error not kept while servo off");
    alarm_hold_a: assert property ((MOTOR_STOP && !ALARM_CLEAR)
        |=> MOTOR_STOP [*1])
        else $error("stop released without alarm clear");
endmodule : smpeg_guard

// ### smpeg_host.sv
/*
 * Host-side model: works out the excess error level it programs.
 * Assumes gain is nonzero and given in tenths per second.
 */
`timescale 1ns/1ps
module smpeg_host
    import smpeg_pkg::*;
(
    // Motion figures
    input wire logic [15:0] max_speed,
    input wire logic [15:0] ppu,
    input wire logic [15:0] gain,
    // Level to program
    output logic [29:0] level
);
    // Steady lag at top speed, doubled so normal runs never trip
    always_comb begin
        level = 30'((32'(max_speed) * 32'(ppu) * 10 / 32'(gain)) * 2 + 1);
    end
endmodule : smpeg_host

// ### smpeg_mon_sel.sv
/*
 * One monitor channel: picks a quantity by its selection code and
 * registers it. Assumes the select code is already a stable register.
 */
`timescale 1ns/1ps
module smpeg_mon_sel
    import smpeg_pkg::*;
(
    // Clock and reset
    input logic clk,
    input logic rst,
    // Selection and quantities
    input logic [3:0] sel,
    smpeg_qty_if.snk qty,
    // Monitor word
    output logic [31:0] mon
);
    logic [31:0] next_mon;

    ////////////////////////////////////////////////////////////////////////
    // Selection; reserved codes give zero
    always_comb begin
        case (sel)
            SEL_SPEED: next_mon = qty.speed;
            SEL_SPD_REF: next_mon = qty.spd_ref;
            SEL_FRC_REF: next_mon = qty.frc_ref;
            SEL_POS_ERR: next_mon = qty.pos_err;
            SEL_AMP_ERR: next_mon = qty.amp_err;
            SEL_REF_SPD: next_mon = qty.ref_spd;
            SEL_POS_DONE: next_mon = qty.pos_done ? LVL_HIGH : LVL_LOW;
            SEL_SPD_FF: next_mon = qty.spd_ff;
            SEL_FRC_FF: next_mon = qty.frc_ff;
            SEL_GAIN: next_mon = qty.gain2 ? LVL_GAIN2 : LVL_GAIN1;
            SEL_REF_DONE: next_mon = qty.ref_done ? LVL_HIGH : LVL_LOW;
            default: next_mon = LVL_LOW;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mon <= 32'h0000_0000;
        end else begin
            mon <= next_mon;
        end
    end

    // Speed selection reaches the output one cycle later
    speed_route_a: assert property (@(posedge clk) disable iff (rst)
        sel == SEL_SPEED |=> mon == $past(qty.speed))
        else $error("monitor did not follow motor speed");
endmodule : smpeg_mon_sel

// ### smpeg_pkg.sv
/*
 * Shared constants and types for the servo monitor and position error
 * guard: monitor select codes, monitor levels, reset values, states.
 * Assumes monitor words are signed millivolt codes for a later DAC.
 */
package smpeg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int DW = 32;
    localparam int LW = 30;

    ////////////////////////////////////////////////////////////////////////
    // Monitor selection codes
    localparam logic [3:0] SEL_SPEED = 4'h0;
    localparam logic [3:0] SEL_SPD_REF = 4'h1;
    localparam logic [3:0] SEL_FRC_REF = 4'h2;
    localparam logic [3:0] SEL_POS_ERR = 4'h3;
    localparam logic [3:0] SEL_AMP_ERR = 4'h4;
    localparam logic [3:0] SEL_REF_SPD = 4'h5;
    localparam logic [3:0] SEL_POS_DONE = 4'h8;
    localparam logic [3:0] SEL_SPD_FF = 4'h9;
    localparam logic [3:0] SEL_FRC_FF = 4'hA;
    localparam logic [3:0] SEL_GAIN = 4'hB;
    localparam logic [3:0] SEL_REF_DONE = 4'hC;

    ////////////////////////////////////////////////////////////////////////
    // Monitor levels in millivolts
    localparam logic [31:0] LVL_HIGH = 32'h0000_1388;
    localparam logic [31:0] LVL_LOW = 32'h0000_0000;
    localparam logic [31:0] LVL_GAIN1 = 32'h0000_03E8;
    localparam logic [31:0] LVL_GAIN2 = 32'h0000_07D0;

    ////////////////////////////////////////////////////////////////////////
    // Values after reset and limits
    localparam logic [3:0] MON1_RST = 4'h2;
    localparam logic [3:0] MON2_RST = 4'h0;
    localparam logic [29:0] EXCESS_RST = 30'h050_0000;
    localparam logic [29:0] SWON_RST = 30'h050_0000;
    localparam logic [29:0] LVL_MIN = 30'h000_0001;
    localparam logic [13:0] CAP_RST = 14'h2710;
    localparam logic [13:0] CAP_MAX = 14'h2710;
    localparam logic [15:0] FCAP_RST = 16'h0064;
    localparam logic [15:0] GAIN_RST = 16'h0190;
    localparam logic [15:0] PPU_RST = 16'h0001;
    localparam logic [51:0] GAIN_SCALE = 52'h0_0000_0000_000A;

    ////////////////////////////////////////////////////////////////////////
    // Control modes and guard states
    typedef enum logic [2:0] {
        MODE_SPEED = 3'h1,
        MODE_POS = 3'h2,
        MODE_FORCE = 3'h4
    } smpeg_mode_t;

    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_RUN = 4'h2,
        ST_CAP = 4'h4,
        ST_STOP = 4'h8
    } smpeg_state_t;

endpackage : smpeg_pkg

// ### smpeg_qty_if.sv
/*
 * Bundle of monitorable quantities passed from the guard to the monitor
 * selectors. Assumes one producer and any number of readers.
 */
`timescale 1ns/1ps
interface smpeg_qty_if;
    logic [31:0] speed;
    logic [31:0] spd_ref;
    logic [31:0] frc_ref;
    logic [31:0] pos_err;
    logic [31:0] amp_err;
    logic [31:0] ref_spd;
    logic [31:0] spd_ff;
    logic [31:0] frc_ff;
    logic pos_done;
    logic gain2;
    logic ref_done;

    modport src (output speed, spd_ref, frc_ref, pos_err, amp_err,
        ref_spd, spd_ff, frc_ff, pos_done, gain2, ref_done);
    modport snk (input speed, spd_ref, frc_ref, pos_err, amp_err,
        ref_spd, spd_ff, frc_ff, pos_done, gain2, ref_done);
endinterface : smpeg_qty_if

// ### tb_smpeg_guard.sv
/*
 * Self-checking bench for smpeg_guard: notes go to a queue, a watcher
 * compares them one edge later. Assumes the host model sets the level.
 */
`timescale 1ns/1ps
module tb_smpeg_guard;
    import smpeg_pkg::*;
    typedef struct {int k; logic [31:0] v;} smpeg_note_t;
    logic REF_CLK = 0, RST = 1, CFG_LOAD = 0, SERVO_ON = 0, NEW_REF = 0;
    logic ALARM_CLEAR = 0, POS_DONE = 0, GAIN2_ACTIVE = 0, REF_DONE = 0;
    logic [3:0] MON1_SEL = 0, MON2_SEL = 0, CLEAR_SETTING = 0;
    logic [2:0] MODE = 3'h2;
    logic [29:0] EXCESS_LEVEL = EXCESS_RST, SWON_LEVEL = SWON_RST;
    logic [13:0] SPEED_CAP = CAP_RST;
    logic [15:0] FWD_FORCE_CAP = FCAP_RST, REV_FORCE_CAP = FCAP_RST;
    logic [15:0] LOOP_GAIN = GAIN_RST, PULSES_PER_UNIT = PPU_RST;
    logic [31:0] POS_REF = 0, POS_ACT = 0, SPEED_FB = 0, SPEED_REF = 0;
    logic [31:0] FORCE_REF = 0, AMP_ERR = 0, REF_SPEED = 0, SPEED_FF = 0;
    logic [31:0] FORCE_FF = 0, MON1, MON2, POS_ERR;
    logic signed [15:0] FORCE_REQ = 0, FORCE_OUT;
    logic ERR_CLEAR, MOTOR_STOP, SPEED_LIMIT_ON, LAG_OVER_STEADY;
    logic EXCESS_ALARM, SWITCH_ON_OVERFLOW_ALARM, SPEED_CAP_OVERFLOW_ALARM;
    logic [13:0] SPEED_LIMIT;
    logic [29:0] host_lvl;
    logic [4:0] flags;
    logic [31:0] clr_lag;
    smpeg_note_t exp_q[$];
    smpeg_note_t n;
    int num_errors = 0, check_count = 0, cycles = 0, rq, fw, rv;

    smpeg_guard dut (.*);
    smpeg_host host (.max_speed(16'h03E8), .ppu(PULSES_PER_UNIT),
        .gain(LOOP_GAIN), .level(host_lvl));
    assign flags = {MOTOR_STOP, SPEED_LIMIT_ON, EXCESS_ALARM,
        SWITCH_ON_OVERFLOW_ALARM, SPEED_CAP_OVERFLOW_ALARM};
    assign clr_lag = {30'h0, ERR_CLEAR, LAG_OVER_STEADY};

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; ceiling well above the sequence length
    always #10 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            $display("ERROR %0t: timeout", $time);
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare tasks, one per kind of result
    task automatic bad(input string what, input logic [31:0] g, e);
        num_errors++;
        $display("ERROR %0t: %s got %h exp %h", $time, what, g, e);
    endtask : bad
    task automatic cmp_word(input string w, input logic [31:0] g, e);
        check_count++;
        if (g !== e) bad(w, g, e);
    endtask : cmp_word
    task automatic cmp_flags(input logic [4:0] g, e);
        check_count++;
        if (g !== e) bad("flags", 32'(g), 32'(e));
    endtask : cmp_flags
    task automatic cmp_force(input logic [15:0] g, e);
        check_count++;
        if (g !== e) bad("force", 32'(g), 32'(e));
    endtask : cmp_force

    // Watcher: outputs have settled 1 ns after the edge
    always @(posedge REF_CLK) begin
        #1;
        while (exp_q.size() > 0) begin
            n = exp_q.pop_front();
            case (n.k)
                0: cmp_word("mon1", MON1, n.v);
                1: cmp_word("mon2", MON2, n.v);
                2: cmp_word("pos_err", POS_ERR, n.v);
                3: cmp_flags(flags, n.v[4:0]);
                5: cmp_word("limit", {18'h0, SPEED_LIMIT}, n.v);
                6: cmp_word("clr_lag", clr_lag, n.v);
                default: cmp_force(FORCE_OUT, n.v[15:0]);
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Driver helpers; go and load return just after a falling edge
    task automatic put(input int k, input logic [31:0] v);
        exp_q.push_back('{k, v});
    endtask : put
    task automatic go(input int c);
        repeat (c) @(negedge REF_CLK);
    endtask : go
    task automatic load();
        CFG_LOAD = 1;
        go(1);
        CFG_LOAD = 0;
        go(1);
    endtask : load
    task automatic print_verdict();
        if (num_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    // Expected monitor word for a select code
    function automatic logic [31:0] mon_exp(input logic [3:0] c);
        case (c)
            SEL_SPEED: return SPEED_FB;
            SEL_SPD_REF: return SPEED_REF;
            SEL_FRC_REF: return FORCE_REF;
            SEL_POS_ERR: return MODE == 3'h2 ? 32'h0000_003C : LVL_LOW;
            SEL_AMP_ERR: return MODE == 3'h2 ? AMP_ERR : LVL_LOW;
            SEL_REF_SPD: return REF_SPEED;
            SEL_POS_DONE: return POS_DONE ? LVL_HIGH : LVL_LOW;
            SEL_SPD_FF: return SPEED_FF;
            SEL_FRC_FF: return FORCE_FF;
            SEL_GAIN: return GAIN2_ACTIVE ? LVL_GAIN2 : LVL_GAIN1;
            SEL_REF_DONE: return REF_DONE ? LVL_HIGH : LVL_LOW;
            default: return LVL_LOW;
        endcase
    endfunction : mon_exp

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'hE03C));
        go(12);
        RST = 0;
        put(3, 32'h0);
        put(5, 32'h0000_2710);
        go(1);
        // Monitor sweep over modes and all codes; kept error is 60
        CLEAR_SETTING = 4'h1;
        POS_REF = 32'h0000_0064;
        POS_ACT = 32'h0000_0028;
        for (int m = 0; m < 3; m++) begin
            MODE = 3'(1 << m);
            for (int c = 0; c < 16; c++) begin
                MON1_SEL = 4'(c);
                MON2_SEL = 4'(15 - c);
                load();
                {SPEED_FB, SPEED_REF, FORCE_REF, AMP_ERR} =
                    {$urandom, $urandom, $urandom, $urandom};
                {REF_SPEED, SPEED_FF, FORCE_FF} = {$urandom, $urandom, $urandom};
                {POS_DONE, GAIN2_ACTIVE, REF_DONE} = 3'($urandom);
                put(0, mon_exp(MON1_SEL));
                put(1, mon_exp(MON2_SEL));
                go(1);
            end
        end
        // Error while off and kept
        repeat (16) begin
            {POS_REF, POS_ACT} = {$urandom, $urandom};
            put(2, POS_REF - POS_ACT);
            put(6, 32'h0);
            go(1);
        end
        CLEAR_SETTING = 4'h0;
        load();
        put(2, 32'h0);
        put(6, 32'h0000_0002);
        go(1);
        // Excess trip in run, from the host's level
        EXCESS_LEVEL = host_lvl;
        SWON_LEVEL = 30'h000_01F4;
        SPEED_CAP = 14'h3FFF;
        MODE = 3'h1;
        POS_REF = 32'h0;
        POS_ACT = 32'h0;
        load();
        SERVO_ON = 1;
        go(3);
        POS_REF = 32'h0000_1388;
        go(3);
        put(3, 32'h0);
        // Let the error settle below the level before position mode
        POS_REF = 32'(host_lvl) - 1;
        go(1);
        MODE = 3'h2;
        go(3);
        // Error 50 at gain 400, one pulse per unit: steady below 2000
        SPEED_FB = 32'h0000_07D0;
        put(6, 32'h0);
        go(1);
        SPEED_FB = 32'h0000_07CF;
        put(6, 32'h0000_0001);
        go(1);
        put(3, 32'h0);
        POS_REF = 32'(host_lvl);
        go(3);
        put(3, 32'h14);
        POS_REF = 32'h0;
        go(4);
        put(3, 32'h14);
        go(1);
        ALARM_CLEAR = 1;
        put(3, 32'h0);
        go(1);
        ALARM_CLEAR = 0;
        SERVO_ON = 0;
        CLEAR_SETTING = 4'h1;
        load();
        // Switch-on check: just above the level trips
        POS_REF = 32'h0000_01F5;
        go(3);
        SERVO_ON = 1;
        go(2);
        put(3, 32'h12);
        go(1);
        ALARM_CLEAR = 1;
        go(1);
        ALARM_CLEAR = 0;
        SERVO_ON = 0;
        // At the level: capped, clamp of the cap value, new reference
        POS_REF = 32'h0000_01F4;
        go(3);
        SERVO_ON = 1;
        go(2);
        put(3, 32'h08);
        put(5, 32'h0000_2710);
        POS_REF = 32'(host_lvl) + 1;
        go(3);
        put(3, 32'h08);
        go(1);
        NEW_REF = 1;
        go(1);
        NEW_REF = 0;
        go(1);
        put(3, 32'h11);
        go(1);
        ALARM_CLEAR = 1;
        go(1);
        ALARM_CLEAR = 0;
        SERVO_ON = 0;
        // Cap lifts once the error is back to zero
        POS_REF = 32'h0000_012C;
        go(3);
        SERVO_ON = 1;
        go(3);
        put(3, 32'h08);
        POS_REF = 32'h0;
        go(3);
        put(3, 32'h0);
        SERVO_ON = 0;
        // Force clamping with random caps
        repeat (16) begin
            fw = int'($urandom_range(200));
            rv = int'($urandom_range(200));
            FWD_FORCE_CAP = 16'(fw);
            REV_FORCE_CAP = 16'(rv);
            load();
            rq = int'($urandom_range(600)) - 300;
            FORCE_REQ = 16'(rq);
            put(4, 32'(rq > fw ? fw : (rq < -rv ? -rv : rq)));
            go(1);
        end
        go(2);
        print_verdict();
    end
endmodule : tb_smpeg_guard
